/* File: verilog/flash_read_device.sv */
// flash side of the single-line read path: command decode, address and data shift
`timescale 1ns/1ns
`default_nettype none

`include "flash_read_defs.svh"

module flash_read_device #(
  parameter int TOP_BIT = `SF_TOP_BIT_32M
) (
  input  wire logic                       arst_n_i,
  spi_flash_if.device                     link,
  input  wire logic                       write_in_progress_flag_i,
  output logic [`SF_ADDR_BITS-1:0]        mem_addr_o,
  input  wire logic [`SF_DATA_BITS-1:0]   mem_data_i,
  output logic                            active_o
);

  // only the three array densities are served
  if (TOP_BIT != `SF_TOP_BIT_32M &&
      TOP_BIT != `SF_TOP_BIT_16M &&
      TOP_BIT != `SF_TOP_BIT_8M) begin : g_bad_top
    $error("flash_read_device: TOP_BIT must be 19, 20 or 21");
  end

  // bits above the density top bit read as don't care
  localparam logic [`SF_ADDR_BITS-1:0] ADDR_MASK =
    `SF_ADDR_BITS'((32'h1 << (TOP_BIT + 1)) - 32'h1);

  localparam logic [4:0] OPC_LAST   = 5'(`SF_OPC_BITS - 1);
  localparam logic [4:0] ADDR_LAST  = 5'(`SF_ADDR_BITS - 1);
  localparam logic [4:0] DUMMY_LAST = 5'(`SF_DUMMY_BITS - 1);
  localparam logic [4:0] BYTE_LAST  = 5'(`SF_DATA_BITS - 1);

  flash_read_pkg::dev_state_t st;
  flash_read_pkg::dev_state_t next_st;
  flash_read_pkg::dev_out_t   out;
  flash_read_pkg::dev_out_t   next_out;

  logic                       frame_rst_n;
  logic [2:0]                 busy_sync;
  logic                       busy_hold;
  logic [`SF_OPC_BITS-1:0]    opc_full;
  logic [`SF_ADDR_BITS-1:0]   addr_full;

  // chip select high clears the whole frame asynchronously, since the
  // link clock stops between frames and no edge can be counted on
  assign frame_rst_n = arst_n_i & ~link.cs_n;

  // the busy flag comes from the array controller's domain; the link clock
  // only runs inside frames, so the opcode's eight edges fill the chain
  always_ff @(posedge link.sck or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_sync <= 3'h0;
      busy_hold <= 1'b0;
    end else begin
      busy_sync <= {busy_sync[1:0], write_in_progress_flag_i};
      if (busy_sync[1] == busy_sync[2]) begin
        busy_hold <= busy_sync[2];
      end
    end
  end

  assign opc_full  = {st.opc[`SF_OPC_BITS-2:0], link.si};
  assign addr_full = {st.addr[`SF_ADDR_BITS-2:0], link.si};

  always_comb begin
    next_st = st;
    unique case (st.phase)
      flash_read_pkg::PH_OPCODE: begin
        next_st.opc = opc_full;
        next_st.cnt = st.cnt + 5'h1;
        if (st.cnt == OPC_LAST) begin
          next_st.cnt = 5'h0;
          if (busy_hold) begin
            // a busy array leaves the frame inert and the cycle untouched
            next_st.phase = flash_read_pkg::PH_IGNORE;
          end else if (opc_full == `SF_OPC_NORMAL) begin
            next_st.phase = flash_read_pkg::PH_ADDR;
            next_st.quick = 1'b0;
          end else if (opc_full == `SF_OPC_QUICK) begin
            next_st.phase = flash_read_pkg::PH_ADDR;
            next_st.quick = 1'b1;
          end else begin
            next_st.phase = flash_read_pkg::PH_IGNORE;
          end
        end
      end
      flash_read_pkg::PH_ADDR: begin
        next_st.addr = addr_full;
        next_st.cnt  = st.cnt + 5'h1;
        if (st.cnt == ADDR_LAST) begin
          next_st.cnt  = 5'h0;
          next_st.addr = addr_full & ADDR_MASK;
          if (st.quick) begin
            next_st.phase = flash_read_pkg::PH_DUMMY;
          end else begin
            next_st.phase = flash_read_pkg::PH_DATA;
          end
        end
      end
      flash_read_pkg::PH_DUMMY: begin
        // dummy bits are clocked in but carry nothing
        next_st.cnt = st.cnt + 5'h1;
        if (st.cnt == DUMMY_LAST) begin
          next_st.cnt   = 5'h0;
          next_st.phase = flash_read_pkg::PH_DATA;
        end
      end
      flash_read_pkg::PH_DATA: begin
        // input line is not looked at once data flows
        next_st.cnt = st.cnt + 5'h1;
        if (st.cnt == BYTE_LAST) begin
          next_st.cnt = 5'h0;
          // masking the sum rolls the top address over to zero
          next_st.addr = (st.addr + `SF_ADDR_BITS'(1)) & ADDR_MASK;
        end
      end
      flash_read_pkg::PH_IGNORE: begin
        next_st = st;
      end
      default: begin
        next_st.phase = flash_read_pkg::PH_IGNORE;
      end
    endcase
  end

  always_ff @(posedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st.phase <= flash_read_pkg::PH_OPCODE;
      st.quick <= 1'b0;
      st.cnt   <= 5'h0;
      st.opc   <= `SF_OPC_BITS'h0;
      st.addr  <= `SF_WRAP_ADDR;
    end else begin
      st <= next_st;
    end
  end

  // output stage launches on the falling edge so the host can sample on
  // the next rising edge with half a clock of margin
  always_comb begin
    next_out.oe = (st.phase == flash_read_pkg::PH_DATA);
    next_out.so = mem_data_i[3'(BYTE_LAST) - st.cnt[2:0]];
  end

  always_ff @(negedge link.sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out <= '0;
    end else begin
      out <= next_out;
    end
  end

  assign link.so_drv = out.so;
  assign link.so_oe  = out.oe;
  assign mem_addr_o  = st.addr;
  assign active_o    = (st.phase == flash_read_pkg::PH_DATA);

endmodule : flash_read_device

`default_nettype wire

/* File: verilog/flash_read_defs.svh */
// constants for the serial flash read path, shared by both ends of the link
`ifndef FLASH_READ_DEFS_SVH
`define FLASH_READ_DEFS_SVH

`define SF_OPC_BITS        8
`define SF_OPC_NORMAL      8'h03
`define SF_OPC_QUICK       8'h0b
`define SF_ADDR_BITS       24
`define SF_DUMMY_BITS      8
`define SF_DATA_BITS       8
`define SF_COUNT_BITS      16
`define SF_WRAP_ADDR       24'h000000

`define SF_TOP_BIT_32M     21
`define SF_TOP_BIT_16M     20
`define SF_TOP_BIT_8M      19

`define SF_NORMAL_MAX_KHZ  33000
`define SF_QUICK_MAX_KHZ   104000
`define SF_REF_PERIOD_NS   40
`define SF_HOST_HALF_DEF   8
`define SF_HOST_HALF_SYNC  6
`define SF_IDLE_LINE       1'b1

`endif

/* File: verilog/flash_read_pkg.sv */
// types for the serial flash read path
`include "flash_read_defs.svh"

package flash_read_pkg;

  typedef enum logic [2:0] {
    PH_OPCODE = 3'h0,
    PH_ADDR   = 3'h1,
    PH_DUMMY  = 3'h2,
    PH_DATA   = 3'h3,
    PH_IGNORE = 3'h4
  } dev_phase_t;

  typedef struct packed {
    dev_phase_t                  phase;
    logic                        quick;
    logic [4:0]                  cnt;
    logic [`SF_OPC_BITS-1:0]     opc;
    logic [`SF_ADDR_BITS-1:0]    addr;
  } dev_state_t;

  typedef struct packed {
    logic so;
    logic oe;
  } dev_out_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_LEAD = 2'h1,
    HS_RUN  = 2'h2,
    HS_TAIL = 2'h3
  } host_phase_t;

  typedef struct packed {
    host_phase_t                                       phase;
    logic [7:0]                                        cnt;
    logic                                              sck;
    logic                                              cs_n;
    logic                                              si;
    logic [`SF_OPC_BITS+`SF_ADDR_BITS+`SF_DUMMY_BITS-1:0] tx;
    logic [5:0]                                        bits;
    logic [`SF_COUNT_BITS-1:0]                         left;
    logic [`SF_DATA_BITS-1:0]                          rx;
    logic [2:0]                                        rxcnt;
    logic [`SF_DATA_BITS-1:0]                          data;
    logic                                              valid;
    logic                                              done;
    logic                                              s1;
    logic                                              s2;
    logic                                              s3;
    logic                                              so_f;
  } host_state_t;

endpackage : flash_read_pkg

/* File: verilog/spi_flash_if.sv */
// single-line spi link between host controller and flash read path
`timescale 1ns/1ns
`default_nettype none

`include "flash_read_defs.svh"

interface spi_flash_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_drv;
  logic so_oe;
  logic so_line;

  // weak pull-up stands in for the released output line
  assign so_line = so_oe ? so_drv : `SF_IDLE_LINE;

  modport device (
    input  cs_n,
    input  sck,
    input  si,
    output so_drv,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input  so_line
  );
endinterface : spi_flash_if

`default_nettype wire

/* File: verilog/flash_read_host.sv */
// spi host end: frames one normal or fast read and returns the bytes
`timescale 1ns/1ns
`default_nettype none

`include "flash_read_defs.svh"

module flash_read_host #(
  parameter int HALF_CYCLES = `SF_HOST_HALF_DEF
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  spi_flash_if.host                       link,
  input  wire logic                       start_i,
  input  wire logic                       quick_i,
  input  wire logic [`SF_ADDR_BITS-1:0]   addr_i,
  input  wire logic [`SF_COUNT_BITS-1:0]  count_i,
  output logic                            busy_o,
  output logic [`SF_DATA_BITS-1:0]        data_o,
  output logic                            data_valid_o,
  output logic                            done_o
);

  // least half period that keeps a normal read at or below its top rate
  localparam int NORMAL_HALF_MIN =
    (1000000 + 2 * `SF_NORMAL_MAX_KHZ * `SF_REF_PERIOD_NS - 1) /
    (2 * `SF_NORMAL_MAX_KHZ * `SF_REF_PERIOD_NS);
  localparam int QUICK_HALF_MIN =
    (1000000 + 2 * `SF_QUICK_MAX_KHZ * `SF_REF_PERIOD_NS - 1) /
    (2 * `SF_QUICK_MAX_KHZ * `SF_REF_PERIOD_NS);

  // the returned line crosses four flops (s1, s2, s3, so_f), so a half period must cover it
  if (HALF_CYCLES < NORMAL_HALF_MIN || HALF_CYCLES < QUICK_HALF_MIN ||
      HALF_CYCLES < `SF_HOST_HALF_SYNC || HALF_CYCLES > 255) begin : g_bad_half
    $error("flash_read_host: HALF_CYCLES out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam int         TXW       = `SF_OPC_BITS + `SF_ADDR_BITS + `SF_DUMMY_BITS;

  flash_read_pkg::host_state_t st;
  flash_read_pkg::host_state_t next_st;

  always_comb begin
    next_st       = st;
    next_st.valid = 1'b0;
    next_st.done  = 1'b0;
    next_st.s1    = link.so_line;
    next_st.s2    = st.s1;
    next_st.s3    = st.s2;
    if (st.s2 == st.s3) begin
      next_st.so_f = st.s3;
    end
    unique case (st.phase)
      flash_read_pkg::HS_IDLE: begin
        if (start_i) begin
          next_st.cs_n  = 1'b0;
          next_st.tx    = {quick_i ? `SF_OPC_QUICK : `SF_OPC_NORMAL, addr_i, `SF_DUMMY_BITS'h0};
          next_st.si    = next_st.tx[TXW-1];
          next_st.bits  = quick_i ? 6'(TXW) : 6'(`SF_OPC_BITS + `SF_ADDR_BITS);
          next_st.left  = count_i;
          next_st.cnt   = 8'h0;
          next_st.rxcnt = 3'h0;
          next_st.phase = flash_read_pkg::HS_LEAD;
        end
      end
      flash_read_pkg::HS_LEAD: begin
        next_st.cnt = st.cnt + 8'h1;
        if (st.cnt == HALF_LAST) begin
          next_st.cnt   = 8'h0;
          next_st.phase = flash_read_pkg::HS_RUN;
        end
      end
      flash_read_pkg::HS_RUN: begin
        next_st.cnt = st.cnt + 8'h1;
        if (st.cnt == HALF_LAST) begin
          next_st.cnt = 8'h0;
          if (!st.sck) begin
            next_st.sck = 1'b1;
            if (st.bits == 6'h0) begin
              next_st.rx    = {st.rx[`SF_DATA_BITS-2:0], st.so_f};
              next_st.rxcnt = st.rxcnt + 3'h1;
              if (st.rxcnt == 3'h7) begin
                next_st.data  = {st.rx[`SF_DATA_BITS-2:0], st.so_f};
                next_st.valid = 1'b1;
                next_st.left  = st.left - `SF_COUNT_BITS'(1);
              end
            end
          end else if (st.bits != 6'h0) begin
            // command bits move msb first while the clock is low
            next_st.sck  = 1'b0;
            next_st.bits = st.bits - 6'h1;
            next_st.tx   = {st.tx[TXW-2:0], 1'b0};
            next_st.si   = st.tx[TXW-2];
          end else if (st.left == `SF_COUNT_BITS'(0)) begin
            next_st.sck   = 1'b0;
            next_st.phase = flash_read_pkg::HS_TAIL;
          end else begin
            next_st.sck = 1'b0;
          end
        end
      end
      flash_read_pkg::HS_TAIL: begin
        next_st.cnt = st.cnt + 8'h1;
        if (st.cnt == HALF_LAST) begin
          next_st.cnt   = 8'h0;
          next_st.cs_n  = 1'b1;
          next_st.si    = 1'b0;
          next_st.done  = 1'b1;
          next_st.phase = flash_read_pkg::HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st       <= '0;
      st.phase <= flash_read_pkg::HS_IDLE;
      st.cs_n  <= 1'b1;
      st.s1    <= `SF_IDLE_LINE;
      st.s2    <= `SF_IDLE_LINE;
      st.s3    <= `SF_IDLE_LINE;
      st.so_f  <= `SF_IDLE_LINE;
    end else begin
      st <= next_st;
    end
  end

  assign link.cs_n    = st.cs_n;
  assign link.sck     = st.sck;
  assign link.si      = st.si;
  assign busy_o       = (st.phase != flash_read_pkg::HS_IDLE);
  assign data_o       = st.data;
  assign data_valid_o = st.valid;
  assign done_o       = st.done;

endmodule : flash_read_host

`default_nettype wire

/* File: verif/flash_link_properties.sv */
// concurrent checks on the spi link between the host and flash read ends
`timescale 1ns/1ns
`default_nettype none

module flash_link_properties (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_drv,
  input wire logic so_oe,
  input wire logic so_line
);
  logic [5:0] rise_cnt;
  logic [7:0] opc;
  logic       sck_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  // link clock is made from ref_clk_i, so counting its rises here is exact
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_cnt <= 6'h00;
      opc      <= 8'h00;
      sck_q    <= 1'b0;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        rise_cnt <= 6'h00;
        opc      <= 8'h00;
      end else if (sck && !sck_q) begin
        if (rise_cnt != 6'h3f) rise_cnt <= rise_cnt + 6'h01;
        if (rise_cnt < 6'h08) opc <= {opc[6:0], si};
      end
    end
  end

  property p_release;
    cs_n |-> !so_oe && so_line;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");

  property p_hiz_cmd;
    !cs_n && rise_cnt < 6'h20 |-> !so_oe;
  endproperty
  a_hiz_cmd: assert property (p_hiz_cmd) else $error("output driven in command phase");

  property p_oe_normal;
    $rose(so_oe) && opc == 8'h03 |-> rise_cnt == 6'h20;
  endproperty
  a_oe_normal: assert property (p_oe_normal) else $error("normal read output at wrong bit");

  property p_oe_quick;
    $rose(so_oe) && opc == 8'h0b |-> rise_cnt == 6'h28;
  endproperty
  a_oe_quick: assert property (p_oe_quick) else $error("fast read output at wrong bit");

  property p_so_fall;
    so_oe && $past(so_oe) && $changed(so_drv) |-> $fell(sck);
  endproperty
  a_so_fall: assert property (p_so_fall) else $error("output bit changed off falling clock");

  property p_si_low;
    !cs_n && $changed(si) |-> !sck;
  endproperty
  a_si_low: assert property (p_si_low) else $error("input bit changed while clock high");

  property p_sck_high;
    $rose(sck) |=> sck;
  endproperty
  a_sck_high: assert property (p_sck_high) else $error("link clock high time too short");

  property p_frame_len;
    $rose(cs_n) |-> rise_cnt >= 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame ended before full address");

  property p_opcode;
    !cs_n && rise_cnt == 6'h08 |-> opc == 8'h03 || opc == 8'h0b;
  endproperty
  a_opcode: assert property (p_opcode) else $error("unknown opcode sent");
endmodule : flash_link_properties

`default_nettype wire

/* File: verif/test_serial_flash_read_engine.sv */
// self-checking bench: host and flash read ends joined over the spi link
`timescale 1ns/1ns
`default_nettype none

module test_serial_flash_read_engine;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i;
  logic        start_i;
  logic        quick_i;
  logic [23:0] addr_i;
  logic [15:0] count_i;
  logic        array_busy;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [7:0]  rd_data;
  logic        busy, valid, done, active;
  int          err_count = 0;
  int          n_tests = 0;

  spi_flash_if lnk ();

  flash_read_host #(.HALF_CYCLES(6)) flash_read_host_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(lnk.host),
    .start_i(start_i), .quick_i(quick_i), .addr_i(addr_i), .count_i(count_i),
    .busy_o(busy), .data_o(rd_data), .data_valid_o(valid), .done_o(done));

  flash_read_device #(.TOP_BIT(21)) flash_read_device_i (
    .arst_n_i(arst_n_i), .link(lnk.device), .write_in_progress_flag_i(array_busy),
    .mem_addr_o(mem_addr), .mem_data_i(mem_data), .active_o(active));

  flash_link_properties flash_link_properties_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cs_n(lnk.cs_n), .sck(lnk.sck),
    .si(lnk.si), .so_drv(lnk.so_drv), .so_oe(lnk.so_oe), .so_line(lnk.so_line));

  // array contents depend on address bits 7:0 and 21:14, so a missed carry above bit 7 shows only once it reaches bit 14
  function automatic logic [7:0] mem_of(input logic [23:0] a);
    return a[7:0] ^ a[21:14] ^ 8'h5a;
  endfunction : mem_of

  assign mem_data = mem_of(mem_addr);

  always #20 ref_clk_i = ~ref_clk_i;

  task automatic results;
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string name, input logic exp, input logic got);
    chk8(name, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic run(input logic q, input logic [23:0] a, input logic [15:0] n, input logic bsy);
    logic [23:0] p;
    logic        seen;
    int          k;
    int          got;
    p = a & 24'h3fffff;
    seen = 1'b0;
    got = 0;
    @(posedge ref_clk_i);
    start_i  <= 1'b1;
    quick_i  <= q;
    addr_i   <= a;
    count_i  <= n;
    array_busy <= bsy;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (active === 1'b1) seen = 1'b1;
      if (valid === 1'b1) begin
        // a refused read leaves the pulled-up line, so every bit reads one
        chk8("data", bsy ? 8'hff : mem_of(p), rd_data);
        p = (p + 24'h1) & 24'h3fffff;
        got++;
      end
    end
    if (k >= 3000) begin
      err_count++;
      results();
    end
    chk8("bytes", n[7:0], got[7:0]);
    chk1("active", !bsy, seen);
  endtask : run

  task automatic t_normal_wrap;
    run(1'b0, 24'hfffffe, 16'h0004, 1'b0);
  endtask : t_normal_wrap

  task automatic t_quick;
    run(1'b1, 24'h123456, 16'h0003, 1'b0);
    run(1'b1, 24'hbfffff, 16'h0002, 1'b0);
  endtask : t_quick

  task automatic t_busy;
    run(1'b0, 24'h000010, 16'h0002, 1'b1);
    run(1'b0, 24'h000010, 16'h0002, 1'b0);
  endtask : t_busy

  task automatic t_abort;
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    quick_i <= 1'b1;
    addr_i  <= 24'h000100;
    count_i <= 16'h0010;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    // far enough in that data is already flowing when the frame is cut
    repeat (600) @(posedge ref_clk_i);
    #1;
    chk1("so_oe_run", 1'b1, lnk.so_oe);
    @(posedge ref_clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk1("cs_n", 1'b1, lnk.cs_n);
    chk1("so_oe", 1'b0, lnk.so_oe);
    chk1("busy", 1'b0, busy);
    arst_n_i <= 1'b1;
    run(1'b0, 24'h0000ff, 16'h0002, 1'b0);
  endtask : t_abort

  initial begin
    arst_n_i = 1'b0;
    start_i = 1'b0;
    quick_i = 1'b0;
    addr_i = 24'h000000;
    count_i = 16'h0000;
    array_busy = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_normal_wrap();
    t_quick();
    t_busy();
    t_abort();
    results();
  end
endmodule : test_serial_flash_read_engine

`default_nettype wire
